// [hw/dcc_top.sv]
// dual capture/compare array with four time bases and a wishbone slave
//
// Design decisions made here: register access over Wishbone and the address map.
`timescale 1ns/100ps
`include "dcc_regs.svh"
// =====================================================================
module dcc_top #(
   parameter int CH = 16                    // channels per array
) (
   input  wire logic            clk_i,      // cpu clock
   input  wire logic            rst_i,      // synchronous reset
   input  wire logic            wb_cyc_i,   // bus cycle
   input  wire logic            wb_stb_i,   // strobe
   input  wire logic            wb_we_i,    // write enable
   input  wire logic [9:0]      wb_adr_i,   // byte address
   input  wire logic [3:0]      wb_sel_i,   // byte lanes
   input  wire logic [31:0]     wb_dat_i,   // write data
   output logic      [31:0]     wb_dat_o,   // read data
   output logic                 wb_ack_o,   // acknowledge
   input  wire logic            gt6_ovf_i,  // general timer six event pulse
   input  wire logic [1:0]      ext_cnt_i,  // external counts, one per array
   input  wire logic [2*CH-1:0] cc_pin_i,   // channel pin levels
   output logic      [2*CH-1:0] cc_pin_o,   // channel pin drive
   output logic      [2*CH-1:0] cc_pin_oe_o,// channel pin enable
   output logic                 irq_o       // level interrupt
);
   import dcc_pkg::*;

   localparam int NCH = 2 * CH;             // channels in total
   localparam int NT  = 4;                  // timers in total

   // ==================================================================
   // functions
   // merge write data into a word by byte lanes
   function automatic logic [31:0] wmerge(input logic [31:0] old,
                                          input logic [31:0] nw,
                                          input logic [3:0]  sel);
      logic [31:0] r;
      r = old;
      for (int b = 0; b < 4; b++) begin
         if (sel[b]) begin
            r[8*b +: 8] = nw[8*b +: 8];
         end
      end
      return r;
   endfunction

   // timer index of a channel from its array and timer choice
   function automatic logic [1:0] tix_f(input int ch, input logic s);
      logic a;
      a = (ch >= CH);
      return {a, s};
   endfunction

   // prescaler hit, factor eight shifted left by the select
   function automatic logic presc_hit(input logic [9:0] d,
                                      input logic [2:0] ps);
      logic [10:0] m;
      m = (`DCC_PS_BASE << ps) - 11'h001;
      return (d & m[9:0]) == m[9:0];
   endfunction

   // ==================================================================
   // storage
   logic [15:0] val_reg  [NCH];             // channel values
   dcc_mode_t   mode_reg [NCH];             // channel modes
   logic [1:0]  edge_reg [NCH];             // capture edges
   logic        tsel_reg [NCH];             // timer choice
   logic [15:0] tcnt_reg [NT];              // timer counts
   logic [15:0] trel_reg [NT];              // timer reloads
   logic [2:0]  tps_reg  [NT];              // prescale selects
   dcc_src_t    tsrc_reg [NT];              // clock sources
   logic        trun_reg [NT];              // run bits
   logic [NCH-1:0] cstat_reg;               // channel events
   logic [NCH-1:0] cmask_reg;               // channel mask
   logic [NT-1:0]  tstat_reg;               // timer overflows
   logic [NT-1:0]  tmask_reg;               // timer mask
   logic [9:0]     div_reg;                 // free prescaler
   logic [1:0]     ext_prev_reg;            // last external count level
   logic [NCH-1:0] pin_prev_reg;            // last pin level
   logic [NCH-1:0] once_reg;                // compare done this period
   logic [NCH-1:0] pin_reg;                 // pin drive state
   logic [NT-1:0]  upd_reg;                 // count just changed
   logic [NT-1:0]  ovf_reg;                 // count just overflowed

   // ==================================================================
   // bus decode
   logic        req;                        // access in this cycle
   logic        wr;                         // write in this cycle
   logic [4:0]  cix;                        // channel index
   logic [1:0]  tix;                        // timer or misc index
   logic        sel_val;                    // value region
   logic        sel_ctl;                    // control region
   logic        sel_tim;                    // timer region
   logic [1:0]  tsub;                       // timer sub-region

   assign req     = wb_cyc_i & wb_stb_i & ~wb_ack_o;
   assign wr      = req & wb_we_i;
   assign cix     = wb_adr_i[6:2];
   assign tix     = wb_adr_i[3:2];
   assign tsub    = wb_adr_i[5:4];
   assign sel_val = (wb_adr_i[9:7] == 3'(`DCC_OFS_VAL >> 7));
   assign sel_ctl = (wb_adr_i[9:7] == 3'(`DCC_OFS_CTL >> 7));
   assign sel_tim = (wb_adr_i[9:6] == 4'(`DCC_OFS_TCNT >> 6));

   // ==================================================================
   // timer ticks
   logic [1:0]    ext_rise;                 // external count edges
   logic [NT-1:0] tick;                     // timer advance
   assign ext_rise = ext_cnt_i & ~ext_prev_reg;

   // source selection per timer
   always_comb begin
      for (int t = 0; t < NT; t++) begin
         case (tsrc_reg[t])
            DCC_SRC_PRESC: tick[t] = presc_hit(div_reg, tps_reg[t]);
            DCC_SRC_GT6:   tick[t] = gt6_ovf_i;
            DCC_SRC_EXT:   tick[t] = (t % 2 == 0) & ext_rise[t / 2];
            default:       tick[t] = 1'b0;
         endcase
         tick[t] = tick[t] & trun_reg[t];
      end
   end

   // free running divider and edge history
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         div_reg      <= 10'h000;
         ext_prev_reg <= 2'h0;
         pin_prev_reg <= '0;
      end else begin
         div_reg      <= div_reg + 10'h001;
         ext_prev_reg <= ext_cnt_i;
         pin_prev_reg <= cc_pin_i;
      end
   end

   // timers and their control
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         for (int t = 0; t < NT; t++) begin
            tcnt_reg[t] <= 16'h0000;
            trel_reg[t] <= 16'h0000;
            tps_reg[t]  <= 3'(`DCC_RST_TCTL >> `DCC_TCTL_PS_LSB);
            tsrc_reg[t] <= DCC_SRC_PRESC;
            trun_reg[t] <= 1'b0;
         end
         upd_reg <= '0;
         ovf_reg <= '0;
      end else begin
         for (int t = 0; t < NT; t++) begin
            upd_reg[t] <= tick[t];
            ovf_reg[t] <= tick[t] & (tcnt_reg[t] == `DCC_TMAX);
            if (wr && sel_tim && tsub == 2'd0 && tix == t) begin
               tcnt_reg[t] <= 16'(wmerge({16'h0, tcnt_reg[t]}, wb_dat_i,
                                         wb_sel_i));
            end else if (tick[t]) begin
               if (tcnt_reg[t] == `DCC_TMAX) begin
                  tcnt_reg[t] <= trel_reg[t];
               end else begin
                  tcnt_reg[t] <= tcnt_reg[t] + 16'h0001;
               end
            end
            if (wr && sel_tim && tsub == 2'd1 && tix == t) begin
               trel_reg[t] <= 16'(wmerge({16'h0, trel_reg[t]}, wb_dat_i,
                                         wb_sel_i));
            end
            if (wr && sel_tim && tsub == 2'd2 && tix == t && wb_sel_i[0]) begin
               tps_reg[t]  <= wb_dat_i[`DCC_TCTL_PS_LSB +: 3];
               tsrc_reg[t] <= dcc_src_t'(wb_dat_i[`DCC_TCTL_SRC_LSB +: 2]);
               trun_reg[t] <= wb_dat_i[`DCC_TCTL_RUN_BIT];
            end
         end
      end
   end

   // ==================================================================
   // channel events
   logic [NCH-1:0] match;                   // equality on a fresh count
   logic [NCH-1:0] evt;                     // compare event after limits
   logic [NCH-1:0] cap;                     // capture event
   logic [NCH-1:0] povf;                    // allocated timer overflowed
   logic [NCH-1:0] dbl_tog;                 // double mode toggle of pin
   logic [NCH-1:0] dbl_own;                 // pin driven by a double pair

   always_comb begin
      for (int c = 0; c < NCH; c++) begin
         logic [1:0] ti;
         logic       rise;
         logic       fall;
         int         lo;
         int         hi;
         ti   = tix_f(c, tsel_reg[c]);
         rise = cc_pin_i[c] & ~pin_prev_reg[c];
         fall = ~cc_pin_i[c] & pin_prev_reg[c];
         lo   = c & ~(CH / 2);
         hi   = c | (CH / 2);
         povf[c]  = ovf_reg[ti];
         match[c] = upd_reg[ti] & (tcnt_reg[ti] == val_reg[c]);
         case (mode_reg[c])
            DCC_CMP0, DCC_CMP1, DCC_DOUBLE: evt[c] = match[c];
            DCC_CMP2, DCC_CMP3: evt[c] = match[c] &
                                    (~once_reg[c] | povf[c]);
            default: evt[c] = 1'b0;
         endcase
         cap[c] = (mode_reg[c] == DCC_CAPTURE) &
                  ((edge_reg[c][0] & rise) | (edge_reg[c][1] & fall));
         // pin of the lower register of a pair
         dbl_tog[c] = (c == lo) &
                      ((mode_reg[c] == DCC_DOUBLE & evt[c]) |
                       (mode_reg[hi] == DCC_DOUBLE & evt[hi]));
         dbl_own[c] = (c == lo) & (mode_reg[c] == DCC_DOUBLE |
                                   mode_reg[hi] == DCC_DOUBLE);
      end
   end

   // channel values, control and capture
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         for (int c = 0; c < NCH; c++) begin
            val_reg[c]  <= `DCC_RST_VAL;
            mode_reg[c] <= DCC_OFF;
            edge_reg[c] <= 2'h0;
            tsel_reg[c] <= 1'b0;
         end
      end else begin
         for (int c = 0; c < NCH; c++) begin
            if (cap[c]) begin
               val_reg[c] <= tcnt_reg[tix_f(c, tsel_reg[c])];
            end else if (wr && sel_val && cix == c) begin
               val_reg[c] <= 16'(wmerge({16'h0, val_reg[c]}, wb_dat_i,
                                        wb_sel_i));
            end
            if (wr && sel_ctl && cix == c && wb_sel_i[0]) begin
               mode_reg[c] <= dcc_mode_t'(wb_dat_i[`DCC_CTL_MODE_LSB +: 3]);
               edge_reg[c] <= wb_dat_i[`DCC_CTL_EDGE_LSB +: 2];
               tsel_reg[c] <= wb_dat_i[`DCC_CTL_TSEL_BIT];
            end
         end
      end
   end

   // once-per-period flags and pin drive
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         once_reg <= '0;
         pin_reg  <= '0;
      end else begin
         for (int c = 0; c < NCH; c++) begin
            // the overflow opens a new period, a fresh event closes it
            once_reg[c] <= (once_reg[c] & ~povf[c]) | evt[c];
            if (dbl_own[c]) begin
               pin_reg[c] <= pin_reg[c] ^ dbl_tog[c];
            end else if (mode_reg[c] == DCC_CMP1) begin
               pin_reg[c] <= pin_reg[c] ^ evt[c];
            end else if (mode_reg[c] == DCC_CMP3) begin
               if (evt[c]) begin
                  pin_reg[c] <= 1'b1;
               end else if (povf[c]) begin
                  pin_reg[c] <= 1'b0;
               end
            end
         end
      end
   end

   // pin enable only for pin-driving modes
   always_comb begin
      for (int c = 0; c < NCH; c++) begin
         cc_pin_oe_o[c] = dbl_own[c] | (mode_reg[c] == DCC_CMP1) |
                          (mode_reg[c] == DCC_CMP3);
      end
   end
   assign cc_pin_o = pin_reg;

   // ==================================================================
   // interrupt status, set wins over clear
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         cstat_reg <= '0;
         cmask_reg <= '0;
         tstat_reg <= '0;
         tmask_reg <= '0;
      end else begin
         logic [31:0] clr;
         clr = (wr && sel_tim && tsub == 2'd3) ?
               wmerge(32'h0, wb_dat_i, wb_sel_i) : 32'h0;
         cstat_reg <= (cstat_reg & ~((tix == 2'd0) ? clr[NCH-1:0] : '0))
                      | cap | evt;
         tstat_reg <= (tstat_reg & ~((tix == 2'd2) ? clr[NT-1:0] : '0))
                      | ovf_reg;
         if (wr && sel_tim && tsub == 2'd3 && tix == 2'd1) begin
            cmask_reg <= NCH'(wmerge(32'(cmask_reg), wb_dat_i, wb_sel_i));
         end
         if (wr && sel_tim && tsub == 2'd3 && tix == 2'd3 && wb_sel_i[0]) begin
            tmask_reg <= wb_dat_i[NT-1:0];
         end
      end
   end
   assign irq_o = |(cstat_reg & cmask_reg) | |(tstat_reg & tmask_reg);

   // ==================================================================
   // read mux and acknowledge
   logic [31:0] rdat;                       // selected read word
   always_comb begin
      rdat = 32'h0;
      if (sel_val) begin
         rdat[15:0] = val_reg[cix];
      end else if (sel_ctl) begin
         rdat[`DCC_CTL_MODE_LSB +: 3] = mode_reg[cix];
         rdat[`DCC_CTL_EDGE_LSB +: 2] = edge_reg[cix];
         rdat[`DCC_CTL_TSEL_BIT]      = tsel_reg[cix];
      end else if (sel_tim) begin
         case (tsub)
            2'd0: rdat[15:0] = tcnt_reg[tix];
            2'd1: rdat[15:0] = trel_reg[tix];
            2'd2: begin
               rdat[`DCC_TCTL_PS_LSB +: 3]  = tps_reg[tix];
               rdat[`DCC_TCTL_SRC_LSB +: 2] = tsrc_reg[tix];
               rdat[`DCC_TCTL_RUN_BIT]      = trun_reg[tix];
            end
            default: begin
               case (tix)
                  2'd0:    rdat[NCH-1:0] = cstat_reg;
                  2'd1:    rdat[NCH-1:0] = cmask_reg;
                  2'd2:    rdat[NT-1:0]  = tstat_reg;
                  default: rdat[NT-1:0]  = tmask_reg;
               endcase
            end
         endcase
      end
   end

   // one wait state, ack for every address
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         wb_ack_o <= 1'b0;
         wb_dat_o <= 32'h0;
      end else begin
         wb_ack_o <= req;
         wb_dat_o <= req ? rdat : 32'h0;
      end
   end
endmodule // dcc_top

// [common/dcc_regs.svh]
// register offsets, field positions and reset values of the capture/compare
`ifndef DCC_REGS_SVH
`define DCC_REGS_SVH

// =====================================================================
// byte offsets
`define DCC_OFS_VAL     10'h000  // channel value, one word per channel
`define DCC_OFS_CTL     10'h080  // channel control, one word per channel
`define DCC_OFS_TCNT    10'h100  // timer count, one word per timer
`define DCC_OFS_TREL    10'h110  // timer reload, one word per timer
`define DCC_OFS_TCTL    10'h120  // timer control, one word per timer
`define DCC_OFS_CSTAT   10'h130  // channel event status, write one clears
`define DCC_OFS_CMASK   10'h134  // channel event mask
`define DCC_OFS_TSTAT   10'h138  // timer overflow status, write one clears
`define DCC_OFS_TMASK   10'h13c  // timer overflow mask

// =====================================================================
// channel control fields
`define DCC_CTL_MODE_LSB 0       // mode, 3 bits
`define DCC_CTL_EDGE_LSB 3       // bit 3 rising, bit 4 falling
`define DCC_CTL_TSEL_BIT 5       // 0 first timer, 1 second timer

// timer control fields
`define DCC_TCTL_PS_LSB  0       // prescale select, 3 bits
`define DCC_TCTL_SRC_LSB 3       // clock source, 2 bits
`define DCC_TCTL_RUN_BIT 5       // timer runs while set

// =====================================================================
// reset values and timing
`define DCC_RST_VAL     16'h0000
`define DCC_RST_CTL     6'h00
`define DCC_RST_TCTL    6'h00
`define DCC_PS_BASE     11'h008  // smallest prescale factor
`define DCC_TMAX        16'hffff // last count before overflow

`endif

// [common/dcc_pkg.sv]
// types shared by the capture/compare array
package dcc_pkg;
   // channel operating modes
   typedef enum logic [2:0] {
      DCC_OFF,
      DCC_CAPTURE,
      DCC_CMP0,
      DCC_CMP1,
      DCC_CMP2,
      DCC_CMP3,
      DCC_DOUBLE
   } dcc_mode_t;

   // timer clock sources
   typedef enum logic [1:0] {
      DCC_SRC_PRESC,
      DCC_SRC_GT6,
      DCC_SRC_EXT
   } dcc_src_t;
endpackage : dcc_pkg

// [verification/dcc_top_sva.sv]
// port checker for the capture/compare block, bound to its top
`timescale 1ns/100ps
module dcc_top_sva #(
   parameter int CH = 16                  // channels per array
) (
   input wire logic            clk_i,       // cpu clock
   input wire logic            rst_i,       // sync reset
   input wire logic            wb_cyc_i,    // bus cycle
   input wire logic            wb_stb_i,    // strobe
   input wire logic            wb_we_i,     // write
   input wire logic [31:0]     wb_dat_o,    // read data
   input wire logic            wb_ack_o,    // acknowledge
   input wire logic [2*CH-1:0] cc_pin_o,    // pin drive
   input wire logic [2*CH-1:0] cc_pin_oe_o, // pin enable
   input wire logic            irq_o        // interrupt
);
   // ===========================================================
   // helper terms
   logic req;                              // request not answered
   logic wr;                               // write being taken
   assign req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
   assign wr  = req & wb_we_i;
   default clocking @(posedge clk_i); endclocking
   default disable iff (rst_i);
   // ===========================================================
   // bus handshake
   property p_ack_next; req |=> wb_ack_o; endproperty
   a_ack_next: assert property (p_ack_next)
      else $error("request not answered in one cycle");
   property p_ack_pulse; wb_ack_o |=> !wb_ack_o; endproperty
   a_ack_pulse: assert property (p_ack_pulse)
      else $error("acknowledge longer than one cycle");
   property p_ack_cause; wb_ack_o |-> $past(req); endproperty
   a_ack_cause: assert property (p_ack_cause)
      else $error("acknowledge without request");
   property p_dat_idle; !wb_ack_o |-> wb_dat_o == 32'h0; endproperty
   a_dat_idle: assert property (p_dat_idle)
      else $error("read data not zero outside acknowledge");
   // ===========================================================
   // reset values, checked the cycle after reset is sampled
   property p_rst_bus;
      disable iff (1'b0) rst_i |=> !wb_ack_o && wb_dat_o == 32'h0;
   endproperty
   a_rst_bus: assert property (p_rst_bus)
      else $error("bus outputs not cleared by reset");
   property p_rst_pin;
      disable iff (1'b0) rst_i |=> cc_pin_o == '0 &&
         cc_pin_oe_o == '0 && !irq_o;
   endproperty
   a_rst_pin: assert property (p_rst_pin)
      else $error("pins or interrupt not cleared by reset");
   // ===========================================================
   // pin enables only move, and interrupt only drops, after a bus write
   property p_oe_hold; !wr |=> $stable(cc_pin_oe_o); endproperty
   a_oe_hold: assert property (p_oe_hold)
      else $error("pin enable changed without control write");
   property p_irq_fall; $fell(irq_o) |-> $past(wr); endproperty
   a_irq_fall: assert property (p_irq_fall)
      else $error("interrupt dropped without a bus write");
   // ===========================================================
   // main scenarios seen
   c_irq: cover property ($rose(irq_o));
   c_pin: cover property (cc_pin_o != $past(cc_pin_o));
   c_wr: cover property (wr ##1 wb_ack_o);
endmodule // dcc_top_sva

bind dcc_top dcc_top_sva #(.CH(CH)) u_sva (.clk_i(clk_i), .rst_i(rst_i),
   .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
   .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .cc_pin_o(cc_pin_o),
   .cc_pin_oe_o(cc_pin_oe_o), .irq_o(irq_o));

// [verification/dcc_pin_model.sv]
// port pins outside the block: sensors drive pins the block releases
`timescale 1ns/100ps
module dcc_pin_model #(
   parameter int N = 32                   // pin count
) (
   input  wire logic [N-1:0] pin_o_i,     // block drive
   input  wire logic [N-1:0] pin_oe_i,    // block enable
   input  wire logic [N-1:0] lvl_i,       // sensor levels
   output logic      [N-1:0] pin_i_o      // resolved pin level
);
   // ===========================================================
   // wire resolution: the block wins where it drives
   always_comb begin
      for (int k = 0; k < N; k++) begin
         pin_i_o[k] = pin_oe_i[k] ? pin_o_i[k] : lvl_i[k];
      end
   end
endmodule // dcc_pin_model

// [verification/testbench.sv]
// self-checking bench for the capture/compare block
`timescale 1ns/100ps
`include "dcc_regs.svh"
module testbench;
   import dcc_pkg::*;
   typedef struct {
      logic [9:0]  adr;                    // register offset
      logic [31:0] wd;                     // written word
      logic [31:0] ex;                     // expected readback
   } dcc_row_t;
   logic        clk_i, wb_ack_o, irq_o;
   logic        rst_i = 1'b1;
   logic        wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
   logic [9:0]  wb_adr_i = 10'h000;
   logic [31:0] wb_dat_i = 32'h0, wb_dat_o, cc_pin_i, cc_pin_o, cc_pin_oe_o;
   logic        gt6_ovf_i = 1'b0;          // timer six pulse
   logic [1:0]  ext_cnt_i = 2'h0;          // external counts
   logic [31:0] lvl = 32'h0;               // sensor levels
   logic [31:0] q;                         // read data
   logic [15:0] tv;                        // expected timer 0 count
   int          n_fail = 0, cmp_count = 0, cyc_n = 0, n;
   dcc_row_t rows [6] = '{
      '{`DCC_OFS_VAL + 10'h00c, 32'hffff5a5a, 32'h00005a5a},
      '{`DCC_OFS_CTL + 10'h004, 32'hffffffff, 32'h0000003f},
      '{`DCC_OFS_TREL + 10'h004, 32'h00001234, 32'h00001234},
      '{`DCC_OFS_TCTL + 10'h00c, 32'h0000003f, 32'h0000003f},
      '{`DCC_OFS_CMASK, 32'h80000001, 32'h80000001},
      '{10'h200, 32'h12345678, 32'h0}};    // unmapped: ignored
   dcc_top #(.CH(16)) dut (.clk_i(clk_i), .rst_i(rst_i),
      .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
      .wb_adr_i(wb_adr_i), .wb_sel_i(4'hf), .wb_dat_i(wb_dat_i),
      .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .gt6_ovf_i(gt6_ovf_i),
      .ext_cnt_i(ext_cnt_i), .cc_pin_i(cc_pin_i), .cc_pin_o(cc_pin_o),
      .cc_pin_oe_o(cc_pin_oe_o), .irq_o(irq_o));
   dcc_pin_model #(.N(32)) pins (.pin_o_i(cc_pin_o),
      .pin_oe_i(cc_pin_oe_o), .lvl_i(lvl), .pin_i_o(cc_pin_i));
   // ===========================================================
   // clock and hang limit
   initial begin
      clk_i = 1'b0;
      forever #20 clk_i = ~clk_i;
   end
   always @(posedge clk_i) begin
      cyc_n <= cyc_n + 1;
      if (cyc_n == 40000) begin
         n_fail = n_fail + 1;
         summarize();
      end
   end
   // ===========================================================
   // bus cycle: hold until ack is sampled, then release
   task automatic xfer(input logic w, input logic [9:0] a,
                       input logic [31:0] d, output logic [31:0] r);
      int t;
      t = 0;
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i  <= w;
      wb_adr_i <= a;
      wb_dat_i <= d;
      @(posedge clk_i);
      while (wb_ack_o !== 1'b1 && t < 20) begin
         @(posedge clk_i);
         t++;
      end
      if (t == 20) n_fail++;
      r = wb_dat_o;
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
      @(posedge clk_i);
   endtask
   task automatic wr(input logic [9:0] a, input logic [31:0] d);
      logic [31:0] u;
      xfer(1'b1, a, d, u);
   endtask
   task automatic rd(input logic [9:0] a, output logic [31:0] r);
      xfer(1'b0, a, 32'h0, r);
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] ex);
      cmp_count++;
      if (got !== ex) begin
         n_fail++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, ex);
      end
   endtask
   // event sources: timer six pulse, array b external count
   task automatic tick();
      gt6_ovf_i <= 1'b1;
      @(posedge clk_i);
      gt6_ovf_i <= 1'b0;
      repeat (4) @(posedge clk_i);
   endtask
   task automatic epulse();
      ext_cnt_i[1] <= 1'b1;
      repeat (2) @(posedge clk_i);
      ext_cnt_i[1] <= 1'b0;
      repeat (5) @(posedge clk_i);
   endtask
   task automatic summarize();
      $display("compares %0d mismatches %0d", cmp_count, n_fail);
      if (n_fail == 0 && cmp_count > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask
   // ===========================================================
   // main sequence
   initial begin
      repeat (8) @(posedge clk_i);
      rst_i <= 1'b0;
      foreach (rows[i]) begin
         wr(rows[i].adr, rows[i].wd);
         rd(rows[i].adr, q);
         chk(q, rows[i].ex);
      end
      rst_i <= 1'b1;                       // reset in mid-run
      repeat (2) @(posedge clk_i);
      rst_i <= 1'b0;
      rd(`DCC_OFS_CTL + 10'h004, q);
      chk(q, {26'h0, `DCC_RST_CTL});
      rd(`DCC_OFS_TREL + 10'h004, q);
      chk(q, {16'h0, `DCC_RST_VAL});
      // capture on each edge selection
      wr(`DCC_OFS_TCTL, 32'h28);
      wr(`DCC_OFS_TCNT, 32'h100);
      tv = 16'h100;
      for (int e = 1; e < 4; e++) begin
         wr(`DCC_OFS_CTL + 10'h008, (e << 3) | 1);
         for (int s = 0; s < 2; s++) begin
            tick();
            tv++;
            wr(`DCC_OFS_CSTAT, 32'hffffffff);
            lvl[2] <= ~lvl[2];
            repeat (4) @(posedge clk_i);
            rd(`DCC_OFS_CSTAT, q);
            chk(q & 32'h4, e[s] ? 32'h4 : 32'h0);
            rd(`DCC_OFS_VAL + 10'h008, q);
            if (e[s]) chk(q, {16'h0, tv});
         end
      end
      wr(`DCC_OFS_CMASK, 32'h4);
      chk(irq_o, 1'b1);
      wr(`DCC_OFS_CMASK, 32'h0);
      chk(irq_o, 1'b0);
      wr(`DCC_OFS_CMASK, 32'h4);
      wr(`DCC_OFS_CSTAT, 32'h4);
      chk(irq_o, 1'b0);
      // interrupt-only compares: many per period, then once
      for (int m = 0; m < 2; m++) begin
         wr(`DCC_OFS_CTL + 10'h010, m ? 32'h4 : 32'h2);
         wr(`DCC_OFS_TCNT, 32'hffff);
         tick();
         rd(`DCC_OFS_TCNT, q);
         chk(q, 32'h0);
         rd(`DCC_OFS_TSTAT, q);
         chk(q & 32'h1, 32'h1);
         wr(`DCC_OFS_TSTAT, 32'h1);
         wr(`DCC_OFS_VAL + 10'h010, 32'h1);
         for (int r = 0; r < 2; r++) begin
            wr(`DCC_OFS_TCNT, 32'h0);
            wr(`DCC_OFS_CSTAT, 32'hffffffff);
            tick();
            rd(`DCC_OFS_CSTAT, q);
            chk(q & 32'h10, (r && m) ? 32'h0 : 32'h10);
         end
      end
      // toggle and set/clear pins
      wr(`DCC_OFS_CTL, 32'h3);
      wr(`DCC_OFS_CTL + 10'h004, 32'h5);
      wr(`DCC_OFS_VAL, 32'h1);
      wr(`DCC_OFS_VAL + 10'h004, 32'h1);
      chk(cc_pin_oe_o & 32'h3, 32'h3);
      for (int k = 1; k < 3; k++) begin
         wr(`DCC_OFS_TCNT, 32'h0);
         tick();
         chk(cc_pin_o[0], k[0]);
         chk(cc_pin_o[1], 1'b1);
      end
      wr(`DCC_OFS_TCNT, 32'hffff);
      tick();
      chk(cc_pin_o[1], 1'b0);
      // every prescale code over a fixed window
      for (int p = 0; p < 8; p++) begin
         n = 2048 >> (p + 3);
         wr(`DCC_OFS_TCTL + 10'h004, 32'h20 | p);
         wr(`DCC_OFS_TCNT + 10'h004, 32'h0);
         repeat (2048) @(posedge clk_i);
         rd(`DCC_OFS_TCNT + 10'h004, q);
         chk(q >= n && q <= n + 1, 1'b1);
      end
      // external counts and a double-register pair
      wr(`DCC_OFS_TCTL + 10'h008, 32'h30);
      wr(`DCC_OFS_TCTL + 10'h00c, 32'h30);
      wr(`DCC_OFS_VAL + 10'h040, 32'h4);
      wr(`DCC_OFS_VAL + 10'h060, 32'h5);
      wr(`DCC_OFS_CTL + 10'h040, 32'h6);
      wr(`DCC_OFS_CTL + 10'h060, 32'h6);
      repeat (3) epulse();
      rd(`DCC_OFS_TCNT + 10'h008, q);
      chk(q, 32'h3);
      rd(`DCC_OFS_TCNT + 10'h00c, q);
      chk(q, 32'h0);
      for (int k = 1; k < 3; k++) begin
         epulse();
         chk(cc_pin_o[16], k[0]);
      end
      chk(cc_pin_oe_o[24], 1'b0);
      summarize();
   end
endmodule // testbench
